// File: design/hsch_defines.svh
// constants for the host serial command handler
// Function
// - set-output message drives configured output pins
// - applied set-output answered by empty acknowledgement
// - input query answered with pin level mask
// - eight two-byte analog values, low byte first
// - results masked to the selected resolution
// - short address 65534 selects long address
// - radio reception reported with fixed field order
// - frames: start, length, type, body, checksum, stop
// - address mode nibbles: destination high, source low
`ifndef HSCH_DEFINES_SVH
`define HSCH_DEFINES_SVH
`define HSCH_SOF          8'h01
`define HSCH_EOF          8'h04
`define HSCH_T_SET_DOUT   8'h20
`define HSCH_T_QRY_DIN    8'h21
`define HSCH_T_QRY_ADC    8'h22
`define HSCH_T_RF_SEND    8'h14
`define HSCH_T_ACK_DOUT   8'ha0
`define HSCH_T_RSP_DIN    8'ha1
`define HSCH_T_RSP_ADC    8'ha2
`define HSCH_T_RF_RECV    8'h95
`define HSCH_OVERHEAD     8'h05
`define HSCH_LEN_ACK      8'h05
`define HSCH_LEN_DIN      8'h07
`define HSCH_LEN_ADC      8'h15
`define HSCH_RF_HDR_BYTES 8'h04
`define HSCH_DOUT_PAYLOAD 8'h02
`define HSCH_SHORT_LONG   16'hfffe
`define HSCH_ADDR_SHORT   4'h0
`define HSCH_SHORT_BYTES  8'h02
`define HSCH_LONG_BYTES   8'h08
`define HSCH_RES_8        2'h0
`define HSCH_RES_10       2'h1
`define HSCH_RES_12       2'h2
`define HSCH_MASK_8       16'h00ff
`define HSCH_MASK_10      16'h03ff
`define HSCH_MASK_12      16'h0fff
`define HSCH_MASK_14      16'h3fff
`define HSCH_FIFO_DEPTH   4
`endif

// File: design/hsch_pkg.sv
// types shared by the host serial command handler
package hsch_pkg;
  typedef struct packed {
    logic [7:0]  pid;
    logic [7:0]  target;
    logic [7:0]  lqi;
    logic [7:0]  mode;
    logic [63:0] dst;
    logic [63:0] src;
    logic [7:0]  ndata;
  } hsch_rf_hdr_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       first;
  } hsch_rf_byte_t;
  typedef enum logic [1:0] {HSCH_K_ACK, HSCH_K_DIN, HSCH_K_ADC, HSCH_K_RX} hsch_kind_t;
  typedef enum logic [2:0] {HSCH_P_SOF, HSCH_P_LEN, HSCH_P_TYPE, HSCH_P_BODY, HSCH_P_SUM, HSCH_P_EOF} hsch_pstate_t;
endpackage

// File: design/hsch_fifo.sv
// small synchronous fifo with registered not-full flag
`timescale 1ns/1ps
module hsch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign out_valid  = (count != '0);
  assign out_data   = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

// File: design/hsch_top.sv
// host serial message interpreter: pins, analog readout and radio bridging
`timescale 1ns/1ps
`include "hsch_defines.svh"
module hsch_top (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // bytes from the host serial receiver
  input  wire logic                  host_rx_valid,
  input  wire logic [7:0]            host_rx_data,
  output logic                       host_rx_ready,
  // bytes to the host serial transmitter
  output logic                       host_tx_valid,
  output logic [7:0]                 host_tx_data,
  input  wire logic                  host_tx_ready,
  // user pins and their configuration
  input  wire logic [15:0]           pin_in,
  input  wire logic [15:0]           pin_is_output,
  input  wire logic [15:0]           pin_is_input,
  output logic [15:0]                pin_out,
  // analog converter results and resolution
  input  wire logic [127:0]          adc_result,
  input  wire logic [1:0]            adc_resolution,
  // node address
  input  wire logic [15:0]           short_addr,
  output logic                       use_long_addr,
  // radio send bytes
  output hsch_pkg::hsch_rf_byte_t    rf_tx,
  output logic                       rf_tx_commit,
  output logic                       rf_tx_abort,
  // radio reception
  input  wire logic                  rf_rx_hdr_valid,
  input  hsch_pkg::hsch_rf_hdr_t     rf_rx_hdr,
  output logic                       rf_rx_hdr_ready,
  input  wire logic                  rf_rx_valid,
  input  wire logic [7:0]            rf_rx_data,
  output logic                       rf_rx_ready
);
  logic [15:0]                pin_meta;
  logic [15:0]                pin_sync;
  hsch_pkg::hsch_pstate_t     pstate;
  logic [7:0]                 plen;
  logic [7:0]                 ptype;
  logic [7:0]                 psum;
  logic [7:0]                 premain;
  logic [7:0]                 pidx;
  logic [15:0]                mask;
  logic                       take;
  logic                       frame_ok;
  logic                       pend_ack;
  logic                       pend_din;
  logic                       pend_adc;
  logic                       pend_rx;
  hsch_pkg::hsch_rf_hdr_t     hdr;
  logic                       busy;
  hsch_pkg::hsch_kind_t       kind;
  logic [7:0]                 elen;
  logic [7:0]                 eidx;
  logic [7:0]                 esum;
  logic [7:0]                 ebyte;
  logic                       edata_phase;
  logic                       adv;
  logic                       fifo_valid;
  logic [7:0]                 fifo_data;
  logic                       fifo_in_ready;

  function automatic logic [7:0] addr_bytes(input logic [3:0] kind_nib);
    return (kind_nib == `HSCH_ADDR_SHORT) ? `HSCH_SHORT_BYTES : `HSCH_LONG_BYTES;
  endfunction

  // byte j of an address sent most significant first
  function automatic logic [7:0] addr_byte(input logic [63:0] a, input logic [7:0] n, input logic [7:0] j);
    logic [7:0] sel;
    sel = n - 8'h01 - j;
    return a[sel[2:0]*8 +: 8];
  endfunction

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    unique case (res)
      `HSCH_RES_8:  return `HSCH_MASK_8;
      `HSCH_RES_10: return `HSCH_MASK_10;
      `HSCH_RES_12: return `HSCH_MASK_12;
      default:      return `HSCH_MASK_14;
    endcase
  endfunction

  // pins arrive from outside the clock domain
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      use_long_addr <= 1'b0;
    end else begin
      use_long_addr <= (short_addr == `HSCH_SHORT_LONG);
    end
  end

  // frame parser
  assign take     = host_rx_valid && host_rx_ready;
  assign frame_ok = (pstate == hsch_pkg::HSCH_P_EOF) && (host_rx_data == `HSCH_EOF);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pstate  <= hsch_pkg::HSCH_P_SOF;
      plen    <= 8'h00;
      ptype   <= 8'h00;
      psum    <= 8'h00;
      premain <= 8'h00;
      pidx    <= 8'h00;
      mask    <= 16'h0000;
    end else if (take) begin
      psum <= psum + host_rx_data;
      unique case (pstate)
        hsch_pkg::HSCH_P_SOF: begin
          psum <= host_rx_data;
          if (host_rx_data == `HSCH_SOF) begin
            pstate <= hsch_pkg::HSCH_P_LEN;
          end
        end
        hsch_pkg::HSCH_P_LEN: begin
          plen    <= host_rx_data;
          premain <= host_rx_data - `HSCH_OVERHEAD;
          pstate  <= (host_rx_data < `HSCH_OVERHEAD) ? hsch_pkg::HSCH_P_SOF : hsch_pkg::HSCH_P_TYPE;
        end
        hsch_pkg::HSCH_P_TYPE: begin
          ptype  <= host_rx_data;
          pidx   <= 8'h00;
          pstate <= (premain == 8'h00) ? hsch_pkg::HSCH_P_SUM : hsch_pkg::HSCH_P_BODY;
        end
        hsch_pkg::HSCH_P_BODY: begin
          if (pidx == 8'h00) begin
            mask[7:0] <= host_rx_data;
          end
          if (pidx == 8'h01) begin
            mask[15:8] <= host_rx_data;
          end
          pidx    <= pidx + 8'h01;
          premain <= premain - 8'h01;
          if (premain == 8'h01) begin
            pstate <= hsch_pkg::HSCH_P_SUM;
          end
        end
        hsch_pkg::HSCH_P_SUM: begin
          // a bad checksum drops the frame silently
          pstate <= (host_rx_data == psum) ? hsch_pkg::HSCH_P_EOF : hsch_pkg::HSCH_P_SOF;
        end
        hsch_pkg::HSCH_P_EOF: begin
          pstate <= hsch_pkg::HSCH_P_SOF;
        end
        default: begin
          pstate <= hsch_pkg::HSCH_P_SOF;
        end
      endcase
    end
  end

  // radio payload streams straight through; the radio discards it on abort
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rf_tx        <= '0;
      rf_tx_commit <= 1'b0;
      rf_tx_abort  <= 1'b0;
    end else begin
      rf_tx.valid  <= take && (pstate == hsch_pkg::HSCH_P_BODY) && (ptype == `HSCH_T_RF_SEND);
      rf_tx.data   <= host_rx_data;
      rf_tx.first  <= (pidx == 8'h00);
      rf_tx_commit <= take && frame_ok && (ptype == `HSCH_T_RF_SEND);
      rf_tx_abort  <= take && (ptype == `HSCH_T_RF_SEND)
                      && (((pstate == hsch_pkg::HSCH_P_SUM) && (host_rx_data != psum))
                          || ((pstate == hsch_pkg::HSCH_P_EOF) && !frame_ok));
    end
  end

  // only pins configured as outputs follow the mask
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out <= 16'h0000;
    end else if (take && frame_ok && (ptype == `HSCH_T_SET_DOUT) && (plen == `HSCH_LEN_DIN)) begin
      pin_out <= (mask & pin_is_output) | (pin_out & ~pin_is_output);
    end
  end

  // pending answers; the parser holds off until its answer is out
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_ack      <= 1'b0;
      pend_din      <= 1'b0;
      pend_adc      <= 1'b0;
      host_rx_ready <= 1'b0;
    end else begin
      if (take && frame_ok) begin
        pend_ack <= (ptype == `HSCH_T_SET_DOUT) && (plen == `HSCH_LEN_DIN);
        pend_din <= (ptype == `HSCH_T_QRY_DIN);
        pend_adc <= (ptype == `HSCH_T_QRY_ADC);
      end else if (adv && (eidx == 8'h00) && (kind != hsch_pkg::HSCH_K_RX)) begin
        pend_ack <= 1'b0;
        pend_din <= 1'b0;
        pend_adc <= 1'b0;
      end
      // deasserted on the stop byte so no further byte is taken before the flags settle
      host_rx_ready <= !(take && frame_ok) && !pend_ack && !pend_din && !pend_adc
                       && !(busy && (kind != hsch_pkg::HSCH_K_RX));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_rx         <= 1'b0;
      hdr             <= '0;
      rf_rx_hdr_ready <= 1'b0;
    end else begin
      if (rf_rx_hdr_valid && rf_rx_hdr_ready) begin
        pend_rx <= 1'b1;
        hdr     <= rf_rx_hdr;
      end else if (adv && (eidx == 8'h00) && (kind == hsch_pkg::HSCH_K_RX)) begin
        pend_rx <= 1'b0;
      end
      rf_rx_hdr_ready <= !pend_rx && !(rf_rx_hdr_valid && rf_rx_hdr_ready);
    end
  end

  // reply emitter
  always_comb begin
    logic [7:0] k;
    logic [7:0] dn;
    logic [7:0] sn;
    logic [15:0] v;
    k           = eidx - 8'h03;
    dn          = addr_bytes(hdr.mode[7:4]);
    sn          = addr_bytes(hdr.mode[3:0]);
    v           = adc_result[k[3:1]*16 +: 16] & res_mask(adc_resolution);
    edata_phase = 1'b0;
    ebyte       = 8'h00;
    if (eidx == 8'h00) begin
      ebyte = `HSCH_SOF;
    end else if (eidx == 8'h01) begin
      ebyte = elen;
    end else if (eidx == 8'h02) begin
      unique case (kind)
        hsch_pkg::HSCH_K_ACK: ebyte = `HSCH_T_ACK_DOUT;
        hsch_pkg::HSCH_K_DIN: ebyte = `HSCH_T_RSP_DIN;
        hsch_pkg::HSCH_K_ADC: ebyte = `HSCH_T_RSP_ADC;
        hsch_pkg::HSCH_K_RX:  ebyte = `HSCH_T_RF_RECV;
      endcase
    end else if (eidx == elen - 8'h02) begin
      ebyte = esum;
    end else if (eidx == elen - 8'h01) begin
      ebyte = `HSCH_EOF;
    end else begin
      unique case (kind)
        hsch_pkg::HSCH_K_ACK: ebyte = 8'h00;
        hsch_pkg::HSCH_K_DIN: ebyte = k[0] ? (pin_sync[15:8] & pin_is_input[15:8])
                                           : (pin_sync[7:0] & pin_is_input[7:0]);
        hsch_pkg::HSCH_K_ADC: ebyte = k[0] ? v[15:8] : v[7:0];
        hsch_pkg::HSCH_K_RX: begin
          if (k == 8'h00) begin
            ebyte = hdr.pid;
          end else if (k == 8'h01) begin
            ebyte = hdr.target;
          end else if (k == 8'h02) begin
            ebyte = hdr.lqi;
          end else if (k == 8'h03) begin
            ebyte = hdr.mode;
          end else if (k < `HSCH_RF_HDR_BYTES + dn) begin
            ebyte = addr_byte(hdr.dst, dn, k - `HSCH_RF_HDR_BYTES);
          end else if (k < `HSCH_RF_HDR_BYTES + dn + sn) begin
            ebyte = addr_byte(hdr.src, sn, k - `HSCH_RF_HDR_BYTES - dn);
          end else begin
            edata_phase = 1'b1;
            ebyte       = fifo_data;
          end
        end
      endcase
    end
  end

  assign adv = busy && (!host_tx_valid || host_tx_ready) && !(edata_phase && !fifo_valid);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      kind <= hsch_pkg::HSCH_K_ACK;
      elen <= 8'h00;
      eidx <= 8'h00;
      esum <= 8'h00;
    end else if (!busy) begin
      eidx <= 8'h00;
      esum <= 8'h00;
      busy <= pend_ack || pend_din || pend_adc || pend_rx;
      if (pend_ack) begin
        kind <= hsch_pkg::HSCH_K_ACK;
        elen <= `HSCH_LEN_ACK;
      end else if (pend_din) begin
        kind <= hsch_pkg::HSCH_K_DIN;
        elen <= `HSCH_LEN_DIN;
      end else if (pend_adc) begin
        kind <= hsch_pkg::HSCH_K_ADC;
        elen <= `HSCH_LEN_ADC;
      end else begin
        kind <= hsch_pkg::HSCH_K_RX;
        elen <= `HSCH_OVERHEAD + `HSCH_RF_HDR_BYTES + addr_bytes(hdr.mode[7:4])
                + addr_bytes(hdr.mode[3:0]) + hdr.ndata;
      end
    end else if (adv) begin
      eidx <= eidx + 8'h01;
      esum <= esum + ebyte;
      if (eidx == elen - 8'h01) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_tx_valid <= 1'b0;
      host_tx_data  <= 8'h00;
    end else if (adv) begin
      host_tx_valid <= 1'b1;
      host_tx_data  <= ebyte;
    end else if (host_tx_ready) begin
      host_tx_valid <= 1'b0;
    end
  end

  // a stalled host backs up into the radio's data bytes
  hsch_fifo #(
    .WIDTH (8),
    .DEPTH (`HSCH_FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    // only bytes the radio saw accepted enter the fifo
    .in_valid  (rf_rx_valid && rf_rx_ready),
    .in_data   (rf_rx_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (adv && edata_phase)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rf_rx_ready <= 1'b0;
    end else begin
      rf_rx_ready <= fifo_in_ready && !(rf_rx_valid && rf_rx_ready);
    end
  end
endmodule

// File: verif/hsch_monitor.sv
// port checker for the host serial command handler
`timescale 1ns/1ps
module hsch_monitor (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // host byte streams
  input wire logic        host_rx_valid,
  input wire logic [7:0]  host_rx_data,
  input wire logic        host_rx_ready,
  input wire logic        host_tx_valid,
  input wire logic [7:0]  host_tx_data,
  input wire logic        host_tx_ready,
  // pins, address and radio send
  input wire logic [15:0] pin_out,
  input wire logic [15:0] short_addr,
  input wire logic        use_long_addr,
  input wire logic        rf_tx_commit,
  input wire logic        rf_tx_abort
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // position, length, type and running sum of the outgoing frame
  logic [7:0] idx;
  logic [7:0] len;
  logic [7:0] typ;
  logic [7:0] sum;
  wire        hs      = host_tx_valid && host_tx_ready;
  wire        last    = idx > 8'h01 && idx == len - 8'h01;
  wire        stop_in = host_rx_valid && host_rx_ready && host_rx_data == 8'h04;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idx <= 8'h00;
      sum <= 8'h00;
    end else if (hs) begin
      idx <= last ? 8'h00 : idx + 8'h01;
      sum <= last ? 8'h00 : sum + host_tx_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      len <= 8'h00;
      typ <= 8'h00;
    end else if (hs && idx == 8'h01) begin
      len <= host_tx_data;
    end else if (hs && idx == 8'h02) begin
      typ <= host_tx_data;
    end
  end
  sequence s_byte;
    host_tx_valid && host_tx_ready;
  endsequence
  sequence s_at(logic [7:0] p);
    s_byte ##0 (idx == p);
  endsequence
  chk_frame_start: assert property (s_at(8'h00) |-> host_tx_data == 8'h01)
    else $error("reply frame does not open with the start byte");
  chk_frame_stop: assert property (s_byte ##0 last |-> host_tx_data == 8'h04)
    else $error("reply frame does not end with the stop byte");
  chk_frame_sum: assert property (s_byte ##0 (idx > 8'h01 && idx == len - 8'h02) |-> host_tx_data == sum)
    else $error("reply checksum wrong");
  chk_reply_len: assert property (s_at(8'h03) |->
    len == (typ == 8'ha0 ? 8'h05 : typ == 8'ha1 ? 8'h07 : typ == 8'ha2 ? 8'h15 : len))
    else $error("reply length does not suit its type");
  chk_tx_hold: assert property (host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data))
    else $error("reply byte dropped or changed while stalled");
  chk_pin_cause: assert property ($changed(pin_out) |-> $past(stop_in))
    else $error("output pins moved without a finished frame");
  chk_long_addr: assert property (!$past(sys_rst) |-> use_long_addr == ($past(short_addr) == 16'hfffe))
    else $error("long address selection wrong");
  chk_rf_commit: assert property (rf_tx_commit |-> $past(stop_in))
    else $error("radio send committed without a stop byte");
  chk_rf_pulse: assert property (rf_tx_commit || rf_tx_abort |=> !rf_tx_commit && !rf_tx_abort)
    else $error("radio send end pulse too long");
endmodule
bind hsch_top hsch_monitor u_monitor (.ref_clk, .sys_rst, .host_rx_valid, .host_rx_data, .host_rx_ready,
  .host_tx_valid, .host_tx_data, .host_tx_ready, .pin_out, .short_addr, .use_long_addr, .rf_tx_commit, .rf_tx_abort);

// File: verif/hsch_host_model.sv
// host application model on the command byte streams
`timescale 1ns/1ps
module hsch_host_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // bytes toward the handler
  output logic            host_rx_valid,
  output logic [7:0]      host_rx_data,
  input  wire logic       host_rx_ready,
  // bytes from the handler
  input  wire logic       host_tx_valid,
  input  wire logic [7:0] host_tx_data,
  output logic            host_tx_ready,
  // stall request from the bench
  input  wire logic       stall
);
  logic [7:0] rx_q[$];
  assign host_tx_ready = !stall;
  initial begin
    host_rx_valid = 1'b0;
    host_rx_data = 8'h00;
  end
  // taken half a cycle early, where valid, data and ready are all settled
  always @(negedge ref_clk) begin
    if (!sys_rst && host_tx_valid && host_tx_ready)
      rx_q.push_back(host_tx_data);
  end
  // whole frames, held until taken; callers wait for the reply first
  task automatic send_bytes(input logic [7:0] b[$]);
    foreach (b[i]) begin
      host_rx_valid <= 1'b1;
      host_rx_data <= b[i];
      @(negedge ref_clk);
      while (!host_rx_ready) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    host_rx_valid <= 1'b0;
    host_rx_data <= ~host_rx_data;  // no stale byte on a released bus
  endtask
endmodule

// File: verif/hsch_top_test.sv
// self-checking bench for the host serial command handler
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module hsch_top_test;
  typedef logic [7:0] hsch_bq_t[$];
  logic                    ref_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    host_rx_valid, host_rx_ready, host_tx_valid, host_tx_ready;
  logic [7:0]              host_rx_data, host_tx_data;
  logic [15:0]             pin_in = 16'h0000, pin_is_output = 16'h0000, pin_is_input = 16'h0000;
  logic [15:0]             pin_out, short_addr = 16'h0000;
  logic [127:0]            adc_result = 128'h0;
  logic [1:0]              adc_resolution = 2'h0, stall_mode = 2'h0;
  logic                    use_long_addr, rf_tx_commit, rf_tx_abort, stall = 1'b0, saw_full = 1'b0;
  hsch_pkg::hsch_rf_byte_t rf_tx;
  hsch_pkg::hsch_rf_hdr_t  rf_rx_hdr = '0;
  logic                    rf_rx_hdr_valid = 1'b0, rf_rx_hdr_ready, rf_rx_valid = 1'b0, rf_rx_ready;
  logic [7:0]              rf_rx_data = 8'h00;
  logic [31:0]             seed = 32'h0000eb89;
  int                      mismatches = 0, num_checks = 0, commits = 0, aborts = 0, full_run = 0;
  hsch_bq_t                rf_q, none;
  hsch_top dut (.ref_clk, .sys_rst, .host_rx_valid, .host_rx_data, .host_rx_ready, .host_tx_valid,
    .host_tx_data, .host_tx_ready, .pin_in, .pin_is_output, .pin_is_input, .pin_out, .adc_result,
    .adc_resolution, .short_addr, .use_long_addr, .rf_tx, .rf_tx_commit, .rf_tx_abort, .rf_rx_hdr_valid,
    .rf_rx_hdr, .rf_rx_hdr_ready, .rf_rx_valid, .rf_rx_data, .rf_rx_ready);
  hsch_host_model host (.ref_clk, .sys_rst, .host_rx_valid, .host_rx_data, .host_rx_ready, .host_tx_valid,
    .host_tx_data, .host_tx_ready, .stall);
  always #12.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic hsch_bq_t frame(input logic [7:0] typ, input hsch_bq_t pl);
    hsch_bq_t f;
    logic [7:0] s;
    f = {8'h01, 8'(pl.size() + 5), typ, pl};
    s = 8'h00;
    foreach (f[i]) s += f[i];
    return {f, s, 8'h04};
  endfunction
  always @(posedge ref_clk) stall <= stall_mode == 2'h2 || (stall_mode == 2'h1 && rnd() % 3 == 0);
  always @(negedge ref_clk) begin
    if (rf_tx.valid) rf_q.push_back(rf_tx.data);
    commits += int'(rf_tx_commit);
    aborts += int'(rf_tx_abort);
    // ready also drops for one cycle after each accept, so only a long refusal means full
    if (rf_rx_valid && !rf_rx_ready) full_run++;
    else full_run = 0;
    if (full_run > 3) saw_full = 1'b1;
  end
  task automatic expect_reply(input string n, input hsch_bq_t e);
    int w;
    logic [7:0] got;
    w = 0;
    while (host.rx_q.size() < e.size() && w < 4000) begin
      @(posedge ref_clk);
      w++;
    end
    foreach (e[i]) begin
      got = host.rx_q.size() > 0 ? host.rx_q.pop_front() : 8'hxx;
      `CHK(n, e[i], got)
    end
  endtask
  // valid stays up between bytes; the caller releases it
  task automatic rf_push(input logic [7:0] d);
    rf_rx_valid <= 1'b1;
    rf_rx_data <= d;
    @(negedge ref_clk);
    while (!rf_rx_ready) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    hsch_bq_t pl, e, dq;
    logic [15:0] m, v;
    logic [7:0] md[3];
    hsch_pkg::hsch_rf_hdr_t h;
    md = '{8'h00, 8'h11, 8'h10};
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin  // worked example first, then random masks
      pin_is_output <= k == 0 ? 16'h4190 : 16'(rnd());
      m = k == 0 ? 16'h0180 : 16'(rnd());
      stall_mode <= 2'(k % 2);
      @(posedge ref_clk);
      host.send_bytes(frame(8'h20, {m[7:0], m[15:8]}));
      expect_reply("ack", frame(8'ha0, none));
      `CHK("pin_out", m & pin_is_output, pin_out & pin_is_output)
    end
    for (int k = 0; k < 3; k++) begin
      v = k == 0 ? 16'h1241 : 16'(rnd());
      m = k == 0 ? 16'h8260 : 16'(rnd());
      pin_in <= v;
      pin_is_input <= m;
      repeat (4) @(posedge ref_clk);  // let the pin synchroniser settle
      m = m & v;
      host.send_bytes(frame(8'h21, none));
      expect_reply("din", frame(8'ha1, {m[7:0], m[15:8]}));
    end
    for (int r = 0; r < 4; r++) begin
      adc_resolution <= 2'(r);
      adc_result <= {rnd(), rnd(), rnd(), rnd()};
      @(posedge ref_clk);
      host.send_bytes(frame(8'h22, none));
      pl.delete();
      for (int c = 0; c < 8; c++) begin
        m = adc_result[16*c +: 16] & ((16'h0001 << (8 + 2 * r)) - 16'h0001);
        pl.push_back(m[7:0]);
        pl.push_back(m[15:8]);
      end
      expect_reply("adc", frame(8'ha2, pl));
    end
    for (int k = 0; k < 4; k++) begin
      v = k % 3 == 0 ? 16'hfffe : 16'hfffd + 16'(k);
      short_addr <= v;
      repeat (2) @(posedge ref_clk);
      `CHK("long_addr", v == 16'hfffe, use_long_addr)
    end
    for (int k = 0; k < 3; k++) begin  // last pass carries a corrupted checksum
      pl = {8'h0a + 8'(k), 8'h11, md[k % 2]};
      repeat (k == 1 ? 8 : 2) pl.push_back(8'(rnd()));
      repeat (1 + k) pl.push_back(8'(rnd()));
      e = frame(8'h14, pl);
      if (k == 2) e[e.size() - 2] = ~e[e.size() - 2];
      rf_q.delete();
      commits = 0;
      aborts = 0;
      host.send_bytes(e);
      repeat (6) @(posedge ref_clk);
      `CHK("rf_bytes", 1'b1, rf_q == pl)
      `CHK("rf_commit", k == 2 ? 0 : 1, commits)
      `CHK("rf_abort", k == 2 ? 1 : 0, aborts)
    end
    for (int k = 0; k < 3; k++) begin  // host stalls first, so the fifo fills and refuses
      h = '{8'h0a, 8'h11, 8'hc8, md[k], {rnd(), rnd()}, {rnd(), rnd()}, 8'h06};
      dq.delete();
      repeat (6) dq.push_back(8'(rnd()));
      pl = {h.pid, h.target, h.lqi, h.mode};
      for (int i = (h.mode[7:4] != 4'h0 ? 7 : 1); i >= 0; i--) pl.push_back(h.dst[8*i +: 8]);
      for (int i = (h.mode[3:0] != 4'h0 ? 7 : 1); i >= 0; i--) pl.push_back(h.src[8*i +: 8]);
      pl = {pl, dq};
      stall_mode <= 2'h2;
      rf_rx_hdr <= h;
      rf_rx_hdr_valid <= 1'b1;
      @(negedge ref_clk);
      while (!rf_rx_hdr_ready) @(negedge ref_clk);
      @(posedge ref_clk);
      rf_rx_hdr_valid <= 1'b0;
      rf_rx_hdr <= ~h;
      fork
        begin
          foreach (dq[i]) rf_push(dq[i]);
          rf_rx_valid <= 1'b0;
          rf_rx_data <= ~rf_rx_data;
        end
        begin
          repeat (60) @(posedge ref_clk);
          stall_mode <= 2'h1;
        end
      join
      expect_reply("rf_rx", frame(8'h95, pl));
    end
    `CHK("fifo_full", 1'b1, saw_full)
    report_and_stop();
  end
endmodule
